// [core/timer16_waveform_mode_control.sv]
// Top: 16-bit waveform timer with AXI4-Lite registers
// How it works
// - Everything runs on aclk; the timer tick is only an enable.
// - Mode is control A bits 1:0 plus two bits in control B.
// - Modes 0, 4, 12: top MAX, A, capture; immediate load; overflow at MAX.
// - Modes 5-7, 14, 15 fast PWM; load and overflow at TOP.
// - Modes 1-3, 10, 11 phase correct; load at TOP, overflow at BOTTOM.
// - Modes 8, 9 phase-frequency correct; load and overflow at BOTTOM.
// - Output mode fields A, B, C at control A bits 7:6, 5:4, 3:2.
// - Nonzero output mode field hands the pin to the waveform.
// - Non-PWM: 01 toggle, 10 clear, 11 set on match.
// - Fast PWM: 10 clear at match set at TOP; 11 inverse.
// - Fast PWM 01 toggles only A, only in modes 14 and 15.
// - Fast PWM match at TOP ignored when upper field bit set.
// - Dual slope: 10 clears counting up, sets counting down; 11 inverse.
// - Dual slope 01 toggles only A, only in modes 8 to 11.
// - Overflow flag sets in the same tick as the BOTTOM load.
// - Clock select: stop, divide 1/8/64/256/1024, external edges.
module timer16_waveform_mode_control
  import timer16_pkg::*;
(
  input  wire logic        aclk,          // I/O clock, 20 MHz
  input  wire logic        aresetn,       // Sync reset, active low
  input  wire logic [9:0]  s_axi_awaddr,  // Write address
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [9:0]  s_axi_araddr,  // Read address
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  input  wire logic        ext_clk_pin,   // External count pin, async
  output logic [2:0]       wave_out,      // Waveforms C,B,A in bits 2:0
  output logic [2:0]       pin_override,  // Waveform owns pin, per channel
  output logic             irq            // Level interrupt
);
  typedef struct packed {
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] count;
    logic [15:0] capture;
    logic        count_up;
    logic [3:0]  status;
    logic [3:0]  mask;
    logic [2:0]  wave;
    logic [2:0]  ovr;
    logic        irq;
  } st_t;
  st_t st_reg, st_next;

  logic        tick;
  logic [3:0]  waveform_mode;
  seq_t        seq;
  upd_t        upd;
  ovf_t        ovf;
  topsrc_t     tsrc;
  logic [15:0] top;
  logic [15:0] fixed_top;
  logic [15:0] cmp_val [3];
  logic [2:0]  cmp_hit;
  logic [2:0]  chan_wave;
  logic [2:0]  cmp_wr;
  logic [1:0]  cmp_mode [3];
  logic        at_top;
  logic        at_bottom;
  logic        load;
  logic        ovf_evt;
  logic        do_wr;
  logic [31:0] wmask;
  logic [31:0] wval;

  assign waveform_mode = {st_reg.ctrl_b[MODE_HI_POS +: 2], st_reg.ctrl_a[MODE_LO_POS +: 2]};
  assign cmp_mode[0] = st_reg.ctrl_a[CMP_A_POS +: 2];
  assign cmp_mode[1] = st_reg.ctrl_a[CMP_B_POS +: 2];
  assign cmp_mode[2] = st_reg.ctrl_a[CMP_C_POS +: 2];

  always_comb begin
    seq = SEQ_NORMAL;
    upd = UPD_NOW;
    ovf = OVF_MAX;
    tsrc = TOP_FIXED;
    fixed_top = TOP_MAX;
    case (waveform_mode)
      4'd1, 4'd2, 4'd3: begin
        seq = SEQ_DUAL;
        upd = UPD_TOP;
        ovf = OVF_BOTTOM;
      end
      4'd4: begin
        seq = SEQ_CLEAR;
        tsrc = TOP_CMPA;
      end
      4'd5, 4'd6, 4'd7: begin
        seq = SEQ_FAST;
        upd = UPD_TOP;
        ovf = OVF_TOP;
      end
      4'd8, 4'd9: begin
        seq = SEQ_DUAL;
        upd = UPD_BOTTOM;
        ovf = OVF_BOTTOM;
        tsrc = waveform_mode[0] ? TOP_CMPA : TOP_CAPT;
      end
      4'd10, 4'd11: begin
        seq = SEQ_DUAL;
        upd = UPD_TOP;
        ovf = OVF_BOTTOM;
        tsrc = waveform_mode[0] ? TOP_CMPA : TOP_CAPT;
      end
      4'd12: begin
        seq = SEQ_CLEAR;
        tsrc = TOP_CAPT;
      end
      4'd14, 4'd15: begin
        seq = SEQ_FAST;
        upd = UPD_TOP;
        ovf = OVF_TOP;
        tsrc = waveform_mode[0] ? TOP_CMPA : TOP_CAPT;
      end
      default: seq = SEQ_NORMAL;
    endcase
    case (waveform_mode[1:0])
      2'd1: fixed_top = TOP_8BIT;
      2'd2: fixed_top = TOP_9BIT;
      2'd3: fixed_top = TOP_10BIT;
      default: fixed_top = TOP_MAX;
    endcase
    if (seq == SEQ_NORMAL) begin
      fixed_top = TOP_MAX;
    end
  end

  assign top = (tsrc == TOP_CMPA) ? cmp_val[0] :
               (tsrc == TOP_CAPT) ? st_reg.capture : fixed_top;
  assign at_top = (st_reg.count == top);
  assign at_bottom = (st_reg.count == BOTTOM);
  // Compare buffers load every cycle in immediate modes, else in the tick the counter sits at the chosen end
  assign load = (upd == UPD_NOW) ||
                (tick && upd == UPD_TOP && at_top) ||
                (tick && upd == UPD_BOTTOM && at_bottom);
  assign ovf_evt = tick && ((ovf == OVF_MAX && st_reg.count == TOP_MAX) ||
                            (ovf == OVF_TOP && at_top) ||
                            (ovf == OVF_BOTTOM && at_bottom && !st_reg.count_up));

  tick_gen u_tick (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .clock_select (st_reg.ctrl_b[CLK_SEL_POS +: 3]),
    .ext_pin      (ext_clk_pin),
    .tick         (tick)
  );

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_chan
      wave_chan u_chan (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .tick       (tick),
        .count      (st_reg.count),
        .top        (top),
        .count_up   (st_reg.count_up),
        .seq        (seq),
        .load       (load),
        .mode       (cmp_mode[g]),
        .tog_ok     ((g == 0) && (seq == SEQ_FAST ? waveform_mode[3:1] == 3'b111
                                                 : waveform_mode[3:2] == 2'b10)),
        .wr         (cmp_wr[g]),
        .wdata      (wval[15:0]),
        .value      (cmp_val[g]),
        .match_flag (cmp_hit[g]),
        .wave       (chan_wave[g])
      );
    end
  endgenerate

  assign do_wr = st_reg.aw_ok && st_reg.w_ok && !st_reg.bvalid;
  assign wmask = {{8{st_reg.w_strb[3]}}, {8{st_reg.w_strb[2]}},
                  {8{st_reg.w_strb[1]}}, {8{st_reg.w_strb[0]}}};
  assign wval = st_reg.w_data & wmask;
  assign cmp_wr[0] = do_wr && st_reg.aw_addr == OFS_CMP_A;
  assign cmp_wr[1] = do_wr && st_reg.aw_addr == OFS_CMP_B;
  assign cmp_wr[2] = do_wr && st_reg.aw_addr == OFS_CMP_C;

  always_comb begin
    st_next = st_reg;
    // Write channel
    if (s_axi_awvalid && !st_reg.aw_ok) begin
      st_next.aw_ok = 1'b1;
      st_next.aw_addr = s_axi_awaddr[9:2]; // Word index, byte lanes ignored
    end
    if (s_axi_wvalid && !st_reg.w_ok) begin
      st_next.w_ok = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.aw_ok = 1'b0;
      st_next.w_ok = 1'b0;
    end
    // Counter sequence advances on the tick only
    if (tick) begin
      case (seq)
        SEQ_DUAL: begin
          if (st_reg.count_up) begin
            if (at_top || st_reg.count > top) begin
              st_next.count_up = 1'b0;
              st_next.count = st_reg.count - 16'h0001;
            end else begin
              st_next.count = st_reg.count + 16'h0001;
            end
          end else if (at_bottom) begin
            st_next.count_up = 1'b1;
            st_next.count = st_reg.count + 16'h0001;
          end else begin
            st_next.count = st_reg.count - 16'h0001;
          end
        end
        SEQ_NORMAL: begin
          st_next.count = st_reg.count + 16'h0001;
          st_next.count_up = 1'b1;
        end
        default: begin
          st_next.count = at_top ? BOTTOM : st_reg.count + 16'h0001;
          st_next.count_up = 1'b1;
        end
      endcase
    end
    // Hardware set beats software clear
    st_next.status = st_reg.status;
    if (do_wr) begin
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      case (st_reg.aw_addr)
        OFS_CTRL_A: st_next.ctrl_a = wval[7:0];
        OFS_CTRL_B: st_next.ctrl_b = wval[7:0] & 8'h1F;
        OFS_COUNT: st_next.count = wval[15:0];
        OFS_CAPTURE: st_next.capture = wval[15:0];
        OFS_CMP_A, OFS_CMP_B, OFS_CMP_C: st_next.bresp = RESP_OKAY;
        OFS_IRQ_STAT: st_next.status = st_reg.status & ~wval[3:0];
        OFS_IRQ_MASK: st_next.mask = wval[3:0];
        default: st_next.bresp = RESP_SLVERR;
      endcase
    end
    st_next.status[IRQ_OVF_BIT] = st_next.status[IRQ_OVF_BIT] | ovf_evt;
    st_next.status[IRQ_CMP_POS +: 3] = st_next.status[IRQ_CMP_POS +: 3] | cmp_hit;
    st_next.irq = |(st_next.status & st_next.mask);
    // Read channel
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      case (s_axi_araddr[9:2])
        OFS_CTRL_A: st_next.rdata = {24'h00_0000, st_reg.ctrl_a};
        OFS_CTRL_B: st_next.rdata = {24'h00_0000, st_reg.ctrl_b};
        OFS_COUNT: st_next.rdata = {16'h0000, st_reg.count};
        OFS_CAPTURE: st_next.rdata = {16'h0000, st_reg.capture};
        OFS_CMP_A: st_next.rdata = {16'h0000, cmp_val[0]};
        OFS_CMP_B: st_next.rdata = {16'h0000, cmp_val[1]};
        OFS_CMP_C: st_next.rdata = {16'h0000, cmp_val[2]};
        OFS_IRQ_STAT: st_next.rdata = {28'h000_0000, st_reg.status};
        OFS_IRQ_MASK: st_next.rdata = {28'h000_0000, st_reg.mask};
        default: begin
          st_next.rdata = 32'h0000_0000;
          st_next.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Pin takeover and waveform levels
    for (int i = 0; i < 3; i++) begin
      st_next.ovr[i] = |cmp_mode[i];
    end
    st_next.wave = chan_wave;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctrl_a <= CTRL_A_RESET;
      st_reg.ctrl_b <= CTRL_B_RESET;
      st_reg.count_up <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready = !st_reg.aw_ok;
  assign s_axi_wready = !st_reg.w_ok;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign wave_out = st_reg.wave;
  assign pin_override = st_reg.ovr;
  assign irq = st_reg.irq;

  a_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (!tick && !do_wr) |=> $stable(st_reg.count)) else $error("count moved w/o tick");
  a_mode_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    waveform_mode == {st_reg.ctrl_b[4:3], st_reg.ctrl_a[1:0]}) else $error("mode");
  a_ctc_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && seq == SEQ_CLEAR && at_top && !do_wr) |=> st_reg.count == BOTTOM)
    else $error("clear-on-match wrap");
  a_fast_top: assert property (@(posedge aclk) disable iff (!aresetn)
    (waveform_mode == 4'd6) |-> top == TOP_9BIT) else $error("fast 9-bit top");
  a_dual_turn: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && seq == SEQ_DUAL && at_top && st_reg.count_up && !do_wr && top != BOTTOM)
    |=> !st_reg.count_up) else $error("no turn at top");
  a_pfc_ovf: assert property (@(posedge aclk) disable iff (!aresetn)
    (upd == UPD_BOTTOM && ovf_evt) |-> load) else $error("ovf without load");
  a_pin_take: assert property (@(posedge aclk) disable iff (!aresetn)
    (cmp_mode[1] != 2'b00) |=> pin_override[1]) else $error("pin not taken");
  a_ovf_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_evt |=> st_reg.status[IRQ_OVF_BIT] ##0 (irq == |(st_reg.status & st_reg.mask)))
    else $error("overflow flag lost");
  a_field_pos: assert property (@(posedge aclk) disable iff (!aresetn)
    cmp_mode[2] == st_reg.ctrl_a[3:2]) else $error("field C position");
endmodule

// [core/timer16_pkg.sv]
// Shared constants for the 16-bit waveform timer
package timer16_pkg;
  // Register word indices; the bus byte address is four times the index
  localparam logic [7:0]  OFS_CTRL_A    = 8'h80;
  localparam logic [7:0]  OFS_CTRL_B    = 8'h81;
  localparam logic [7:0]  OFS_COUNT     = 8'h84;
  localparam logic [7:0]  OFS_CAPTURE   = 8'h86;
  localparam logic [7:0]  OFS_CMP_A     = 8'h88;
  localparam logic [7:0]  OFS_CMP_B     = 8'h8A;
  localparam logic [7:0]  OFS_CMP_C     = 8'h8C;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h94;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h98;
  localparam logic [7:0]  CTRL_A_RESET  = 8'h00;
  localparam logic [7:0]  CTRL_B_RESET  = 8'h00;
  localparam int          CMP_A_POS     = 6;
  localparam int          CMP_B_POS     = 4;
  localparam int          CMP_C_POS     = 2;
  localparam int          MODE_LO_POS   = 0;
  localparam int          MODE_HI_POS   = 3;
  localparam int          CLK_SEL_POS   = 0;
  localparam int          IRQ_OVF_BIT   = 0;
  localparam int          IRQ_CMP_POS   = 1;
  localparam logic [15:0] TOP_MAX       = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT      = 16'h00FF;
  localparam logic [15:0] TOP_9BIT      = 16'h01FF;
  localparam logic [15:0] TOP_10BIT     = 16'h03FF;
  localparam logic [15:0] BOTTOM        = 16'h0000;
  localparam logic [10:0] DIV_8         = 11'h0008;
  localparam logic [10:0] DIV_64        = 11'h0040;
  localparam logic [10:0] DIV_256       = 11'h0100;
  localparam logic [10:0] DIV_1024      = 11'h0400;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  typedef enum logic [1:0] {SEQ_NORMAL, SEQ_CLEAR, SEQ_FAST, SEQ_DUAL} seq_t;
  typedef enum logic [1:0] {UPD_NOW, UPD_TOP, UPD_BOTTOM} upd_t;
  typedef enum logic [1:0] {OVF_MAX, OVF_TOP, OVF_BOTTOM} ovf_t;
  typedef enum logic [1:0] {TOP_FIXED, TOP_CMPA, TOP_CAPT} topsrc_t;
endpackage

// [core/tick_gen.sv]
// Prescaler and external-edge timer tick enable
module tick_gen
  import timer16_pkg::*;
(
  input  wire logic       aclk,          // I/O clock
  input  wire logic       aresetn,       // Sync reset, active low
  input  wire logic [2:0] clock_select,  // Tick source
  input  wire logic       ext_pin,       // External count pin, async
  output logic            tick           // One-cycle tick enable
);
  typedef struct packed {
    logic [10:0] div;
    logic [2:0]  sync;
    logic        tick;
  } st_t;
  st_t st_reg, st_next;
  logic [10:0] lim;
  always_comb begin
    st_next = st_reg;
    lim = 11'h0001;
    st_next.sync = {st_reg.sync[1:0], ext_pin};
    st_next.div = st_reg.div + 11'h0001;
    st_next.tick = 1'b0;
    case (clock_select)
      3'h2: lim = DIV_8;
      3'h3: lim = DIV_64;
      3'h4: lim = DIV_256;
      3'h5: lim = DIV_1024;
      default: lim = 11'h0001;
    endcase
    if (st_next.div >= lim) begin
      st_next.div = 11'h0000;
    end
    case (clock_select)
      3'h0: st_next.tick = 1'b0;
      3'h1: st_next.tick = 1'b1;
      3'h6: st_next.tick = st_reg.sync[2] & ~st_reg.sync[1];
      3'h7: st_next.tick = ~st_reg.sync[2] & st_reg.sync[1];
      default: st_next.tick = (st_reg.div == lim - 11'h0001);
    endcase
    if (clock_select == 3'h0) begin
      st_next.div = 11'h0000;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign tick = st_reg.tick;
endmodule

// [core/wave_chan.sv]
// One compare channel: buffered compare value and output action
module wave_chan
  import timer16_pkg::*;
(
  input  wire logic        aclk,       // I/O clock
  input  wire logic        aresetn,    // Sync reset, active low
  input  wire logic        tick,       // Timer tick enable
  input  wire logic [15:0] count,      // Counter value
  input  wire logic [15:0] top,        // Current TOP
  input  wire logic        count_up,   // Counting direction
  input  wire seq_t        seq,        // Count sequence
  input  wire logic        load,       // Load compare from buffer
  input  wire logic [1:0]  mode,       // Compare output mode field
  input  wire logic        tog_ok,     // Toggle allowed in PWM modes
  input  wire logic        wr,         // Buffer write strobe
  input  wire logic [15:0] wdata,      // Buffer write data
  output logic [15:0]      value,      // Active compare value
  output logic             match_flag, // Match event pulse
  output logic             wave        // Waveform level
);
  typedef struct packed {
    logic [15:0] buffer;
    logic [15:0] value;
    logic        matched;
    logic        wave;
  } st_t;
  st_t st_reg, st_next;
  logic hit;
  always_comb begin
    st_next = st_reg;
    hit = tick && (count == st_reg.value);
    if (wr) begin
      st_next.buffer = wdata;
    end
    if (load) begin
      st_next.value = st_next.buffer;
    end
    st_next.matched = hit;
    case (seq)
      SEQ_FAST: begin
        if (hit && !(mode[1] && st_reg.value == top)) begin
          if (mode == 2'b10) st_next.wave = 1'b0;
          else if (mode == 2'b11) st_next.wave = 1'b1;
          else if (mode == 2'b01 && tog_ok) st_next.wave = ~st_reg.wave;
        end else if (tick && count == top && mode[1]) begin
          st_next.wave = ~mode[0];
        end
      end
      SEQ_DUAL: begin
        if (hit) begin
          if (mode[1]) st_next.wave = mode[0] ~^ count_up;
          else if (mode == 2'b01 && tog_ok) st_next.wave = ~st_reg.wave;
        end
      end
      default: begin
        if (hit) begin
          case (mode)
            2'b01: st_next.wave = ~st_reg.wave;
            2'b10: st_next.wave = 1'b0;
            2'b11: st_next.wave = 1'b1;
            default: st_next.wave = st_reg.wave;
          endcase
        end
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign value = st_reg.value;
  assign match_flag = st_reg.matched;
  assign wave = st_reg.wave;
  a_match_next: assert property (@(posedge aclk) disable iff (!aresetn)
    (tick && count == value) |=> match_flag) else $error("match flag late");
endmodule

// [testbench/gpio_pin_model.sv]
// Port pins that carry the timer's compare waveforms
module gpio_pin_model (
  input  wire logic [2:0] wave_out,     // Timer waveforms C,B,A
  input  wire logic [2:0] pin_override, // Waveform owns the pin
  input  wire logic [2:0] dir_out,      // Direction bits, 1 = output
  input  wire logic [2:0] port_val,     // Plain port data
  output logic      [2:0] pin_level     // Level seen on the pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Undriven pin floats to the pull-up, so override alone shows nothing
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!dir_out[i]) pin_level[i] = 1'b1;
      else pin_level[i] = pin_override[i] ? wave_out[i] : port_val[i];
    end
  end
endmodule

// [testbench/timer16_waveform_mode_control_bench.sv]
// Self-checking bench: registers, waveform modes, interrupt
module timer16_waveform_mode_control_bench;
  import timer16_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_t;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic        ext_pin = 0;
  logic [2:0]  dir_out = '0, port_val = '0;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [2:0]  wave_out, pin_override, pin_level;
  note_t       q[$];
  note_t       e;
  int          error_cnt = 0, check_count = 0;
  always #25 aclk = ~aclk;
  timer16_waveform_mode_control i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clk_pin(ext_pin), .wave_out(wave_out), .pin_override(pin_override), .irq(irq));
  gpio_pin_model i_pins (.wave_out(wave_out), .pin_override(pin_override),
    .dir_out(dir_out), .port_val(port_val), .pin_level(pin_level));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] r = RESP_OKAY);
    bit b = 0;
    @(posedge aclk);
    awaddr <= {a, 2'b00};
    awvalid <= 1;
    wdata <= d;
    wvalid <= 1;
    bready <= 1;
    for (int n = 0; n < 50 && !b; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) b = 1;
    end
    bready <= 0;
    check("bresp", {b, bresp}, {1'b1, r});
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d, logic [31:0] m = 32'hFFFF_FFFF,
                    logic [1:0] r = RESP_OKAY);
    bit g = 0;
    q.push_back('{d & m, m, r});
    @(posedge aclk);
    araddr <= {a, 2'b00};
    arvalid <= 1;
    rready <= 1;
    for (int n = 0; n < 50 && !g; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) g = 1;
    end
    rready <= 0;
    check("rvalid", g, 1);
  endtask
  // Read results are paired with the oldest note as they arrive
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      e = q.pop_front();
      check("rdata", rdata & e.m, e.d);
      check("rresp", rresp, e.r);
    end
  end
  // Settle one window so buffered compares have loaded, then measure pin A
  task automatic run(logic [3:0] md, logic [1:0] fa, logic [15:0] cp, logic [15:0] ca,
                     int win, logic [1:0] st, output int hi, output int tog);
    logic p;
    hi = 0;
    tog = 0;
    wr(OFS_CTRL_B, 0);
    wr(OFS_CAPTURE, cp);
    wr(OFS_CMP_A, ca);
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL_A, {fa, 4'h0, md[1:0]});
    wr(OFS_CTRL_B, {2{3'h0, md[3:2], 3'h1}});
    repeat (win) @(posedge aclk);
    wr(OFS_IRQ_STAT, 32'h0000_000F);
    @(posedge aclk);
    p = pin_level[0];
    repeat (win) begin
      @(posedge aclk);
      hi += pin_level[0];
      tog += (pin_level[0] !== p);
      p = pin_level[0];
    end
    rd(OFS_IRQ_STAT, st, 32'h0000_0003);
  endtask
  initial begin
    int h1, t1, h2, t2;
    logic [7:0] v;
    void'($urandom(19637));
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    check("pins", pin_level, 3'h7);
    dir_out <= 3'h7;
    rd(OFS_CTRL_A, CTRL_A_RESET);
    rd(8'hA0, 0, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(8'hA0, 32'h0000_0001, RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      wr(OFS_CTRL_A, v);
      rd(OFS_CTRL_A, v);
      check("override", pin_override, {|v[3:2], |v[5:4], |v[7:6]});
    end
    run(4'd14, 2'h2, 16'h0013, 16'h0005, 40, 2'h3, h1, t1);
    run(4'd14, 2'h3, 16'h0013, 16'h0005, 40, 2'h3, h2, t2);
    check("fast duty", h1 + h2, 40);
    check("fast high", h1, 12);
    run(4'd10, 2'h2, 16'h0013, 16'h0005, 76, 2'h3, h1, t1);
    run(4'd10, 2'h3, 16'h0013, 16'h0005, 76, 2'h3, h2, t2);
    check("dual duty", h1 + h2, 76);
    check("dual high", h1, 20);
    run(4'd15, 2'h1, 16'h0000, 16'h0013, 40, 2'h3, h1, t1);
    check("fast toggle", t1, 2);
    run(4'd5, 2'h1, 16'h0000, 16'h0013, 600, 2'h3, h1, t1);
    check("fast no toggle", t1, 0);
    run(4'd9, 2'h1, 16'h0000, 16'h0013, 76, 2'h3, h1, t1);
    check("dual toggle", t1, 2);
    run(4'd1, 2'h1, 16'h0000, 16'h0013, 1100, 2'h3, h1, t1);
    check("dual no toggle", t1, 0);
    run(4'd4, 2'h3, 16'h0000, 16'h0013, 40, 2'h2, h1, t1);
    check("ctc set", h1, 40);
    run(4'd4, 2'h1, 16'h0000, 16'h0013, 40, 2'h2, h1, t1);
    check("ctc toggle", t1, 2);
    wr(OFS_IRQ_MASK, 0);
    repeat (25) @(posedge aclk);
    check("irq masked", irq, 0);
    wr(OFS_IRQ_MASK, 32'h0000_0002);
    @(posedge aclk);
    check("irq raised", irq, 1);
    rd(OFS_IRQ_MASK, 32'h0000_0002);
    wr(OFS_CTRL_B, 0);
    wr(OFS_IRQ_STAT, 32'h0000_0002);
    @(posedge aclk);
    check("irq cleared", irq, 0);
    rd(OFS_IRQ_STAT, 0, 32'h0000_0002);
    // Five rising and five falling pin edges, each wide enough for the synchroniser
    for (int k = 6; k < 8; k++) begin
      wr(OFS_COUNT, 0);
      wr(OFS_CTRL_B, k);
      repeat (10) begin
        repeat (4) @(posedge aclk);
        ext_pin <= ~ext_pin;
      end
      repeat (8) @(posedge aclk);
      wr(OFS_CTRL_B, 0);
      rd(OFS_COUNT, 32'h0000_0005);
    end
    // Divide by 8 over 80 cycles; low bits masked for bus latency
    wr(OFS_COUNT, 0);
    wr(OFS_CTRL_B, 32'h0000_0002);
    repeat (80) @(posedge aclk);
    wr(OFS_CTRL_B, 0);
    rd(OFS_COUNT, 32'h0000_0008, 32'h0000_FFF8);
    final_report();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    error_cnt++;
    final_report();
  end
endmodule
